// ### async_serial_receiver_addr_detect_bench.sv
/*
 self-checking bench for the serial receiver: avalon-mm tasks plus frames.
 assumes the design's defines header and a 100 MHz clock.
*/
`timescale 1ns/1ns
`include "serial_rx_defines.svh"
module async_serial_receiver_addr_detect_bench;
	// enable, receive, irq enable, high speed, global and peripheral irq
	localparam logic [31:0] BASE = 32'h0000_06a9;
	logic clk, sys_rst, read, write, waitrequest, irq_high, irq_low, rx_line;
	logic [3:0] address;
	logic [31:0] writedata, readdata, q;
	int errors, checked;

	serial_rx dut_u (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .serial_rx_pin(rx_line), .irq_high(irq_high),
		.irq_low(irq_low));
	serial_tx_model tx_u (.clk(clk), .line(rx_line));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task report_and_stop;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	// raised after an edge, held until waitrequest is sampled low at a rising edge
	// data taken and request dropped at that edge; one idle edge before the next call
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50)
		begin
			errors++;
			report_and_stop;
		end
	endtask

	// bounded wait for either interrupt level
	task wirq;
		int n;
		n = 0;
		while (irq_low !== 1'b1 && irq_high !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 100)
		begin
			errors++;
			report_and_stop;
		end
	endtask

	initial
	begin
		sys_rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0000_0000;
		errors = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		bus(0, `OFS_CTRL, 0);
		chk("ctrl rst", `CTRL_RST, q[10:0]);
		bus(0, `OFS_BAUD, 0);
		chk("baud rst", `BAUD_RST, q[15:0]);
		bus(0, 4'h2, 0);
		chk("unmapped", 0, q);
		// divisor 1 high speed (32 clk bits), then divisor 0 low speed (64)
		// high byte set but ignored: wide counter is off
		for (int i = 0; i < 2; i++)
		begin
			bus(1, `OFS_BAUD, 32'h0000_0101 - i);
			bus(1, `OFS_CTRL, BASE & ~(i << `CTRL_HIGH_SPEED_BAUD_SELECT));
			tx_u.send(9'h0a5 + i, 8, 32 << i, 1'b1);
			wirq;
			chk("irq_low", 1, irq_low);
			chk("irq_high", 0, irq_high);
			bus(0, `OFS_STATUS, 0);
			chk("flag", 1, q[`ST_RXIF]);
			bus(0, `OFS_DATA, 0);
			chk("data", 8'ha5 + i, q[7:0]);
			bus(0, `OFS_STATUS, 0);
			chk("flag clr", 0, q[`ST_RXIF]);
			chk("irq off", 0, irq_low);
		end
		bus(1, `OFS_BAUD, 0);
		// receiver off, then clocked mode selected: character ignored
		for (int j = 0; j < 2; j++)
		begin
			bus(1, `OFS_CTRL, j ? (BASE | 32'h0000_0002) : (BASE & ~32'h0000_0008));
			tx_u.send(9'h033, 8, 16, 1'b1);
			repeat (20) @(posedge clk);
			bus(0, `OFS_STATUS, 0);
			chk("no flag off", 0, q[`ST_RXIF]);
		end
		// global gate closed, then peripheral gate closed, then both opened
		bus(1, `OFS_CTRL, BASE & ~32'h0000_0200);
		tx_u.send(9'h05a, 8, 16, 1'b1);
		repeat (20) @(posedge clk);
		chk("gated irq", 0, irq_low);
		bus(1, `OFS_CTRL, BASE & ~32'h0000_0400);
		repeat (4) @(posedge clk);
		chk("gated irq p", 0, irq_low);
		bus(1, `OFS_CTRL, BASE);
		wirq;
		chk("ungated irq", 1, irq_low);
		bus(0, `OFS_DATA, 0);
		chk("data gate", 8'h5a, q[7:0]);
		// nine bits, high priority
		bus(1, `OFS_CTRL, BASE | 32'h0000_0044);
		tx_u.send(9'h13c, 9, 16, 1'b1);
		wirq;
		chk("irq_high 9", 1, irq_high);
		bus(0, `OFS_STATUS, 0);
		chk("ninth", 1, q[`ST_NINTH]);
		bus(0, `OFS_DATA, 0);
		chk("data 9", 8'h3c, q[7:0]);
		// address detect: data character dropped, address kept
		bus(1, `OFS_CTRL, BASE | 32'h0000_0014);
		tx_u.send(9'h055, 9, 16, 1'b1);
		repeat (20) @(posedge clk);
		bus(0, `OFS_STATUS, 0);
		chk("addr drop", 0, q[`ST_RXIF]);
		tx_u.send(9'h1aa, 9, 16, 1'b1);
		wirq;
		bus(0, `OFS_DATA, 0);
		chk("addr", 8'haa, q[7:0]);
		bus(1, `OFS_CTRL, BASE | 32'h0000_0004);
		tx_u.send(9'h011, 9, 16, 1'b1);
		wirq;
		bus(0, `OFS_DATA, 0);
		chk("all pass", 8'h11, q[7:0]);
		// two unread characters overrun, a bad stop bit frames wrong; both latch until off
		bus(1, `OFS_CTRL, BASE);
		tx_u.send(9'h077, 8, 16, 1'b1);
		tx_u.send(9'h078, 8, 16, 1'b1);
		tx_u.send(9'h079, 8, 16, 1'b0);
		repeat (40) @(posedge clk);
		bus(0, `OFS_STATUS, 0);
		chk("ferr", 1, q[`ST_FERR]);
		chk("oerr", 1, q[`ST_OERR]);
		bus(1, `OFS_CTRL, BASE & ~32'h0000_0008);
		bus(0, `OFS_STATUS, 0);
		chk("ferr clr", 0, q[`ST_FERR]);
		chk("oerr clr", 0, q[`ST_OERR]);
		report_and_stop;
	end
endmodule

// ### serial_rx.sv
/*
 asynchronous serial receiver with 9-bit address detect and an avalon-mm register slave.
 assumes serial_rx_pin is already synchronous to clk and idles high.
*/
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "serial_rx_defines.svh"

// Function
// RULE1: recover bits with sixteen-times baud oversampling
// RULE2: main shifter advances once per bit
// RULE3: baud divisor and speed bits set timing
// RULE4: asynchronous only when enabled, clocked-mode clear
// RULE5: nine data bits when ninth-bit enabled
// RULE6: accept characters only while continuous receive
// RULE7: completion sets flag, enabled interrupt request
// RULE8: status shows ninth bit and errors
// RULE9: data register returns low eight bits
// RULE10: clearing continuous receive clears latched errors
// RULE11: interrupt gated by global and peripheral enables
// RULE12: priority bit selects interrupt level
// RULE13: address detect needs nine-bit mode
// RULE14: software reads data to judge addressing
// RULE15: without address detect every character loads; a bad stop bit or a latched overrun keeps one from loading
// RULE16: address detect keeps only ninth-bit-set characters
// RULE17: frame is start, lsb-first data, stop
module serial_rx
	import serial_rx_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// serial line
	input wire logic serial_rx_pin,
	// interrupts
	output logic irq_high,
	output logic irq_low
);
	logic [10:0] ctrl_ff;
	logic [15:0] baud_ff;
	logic [15:0] baud_cnt_ff;
	logic [3:0] ovs_cnt_ff;
	logic [3:0] bit_cnt_ff;
	logic [8:0] shift_ff;
	logic [8:0] data_ff;
	logic ninth_ff;
	logic ferr_ff;
	logic oerr_ff;
	logic rxif_ff;
	logic ack_ff;
	rx_state_e state_ff;
	logic tick;
	logic [15:0] div_val;
	logic sample;
	logic frame_done;
	logic load_char;
	logic [3:0] nbits;
	logic rd_data;
	logic wr_ctrl;
	logic port_on;
	logic [3:0] ovs_sel;

	// one-cycle wait: every access answers on the second edge
	assign rd_data = read && !ack_ff && address == `OFS_DATA;
	assign wr_ctrl = write && !ack_ff && address == `OFS_CTRL;
	assign port_on = ctrl_ff[`CTRL_SERIAL_PORT_ENABLE] && !ctrl_ff[`CTRL_CLKMODE]; // RULE4
	assign nbits = ctrl_ff[`CTRL_RX9] ? 4'd9 : 4'd8; // RULE5

	// divisor: wide counter uses both bytes, else low byte only
	assign div_val = ctrl_ff[`CTRL_WIDE_BAUD_COUNTER_SELECT] ? baud_ff : {8'h00, baud_ff[7:0]}; // RULE3
	// high speed gives sixteen ticks per bit, low speed sixty-four ticks (x4)
	assign ovs_sel = ctrl_ff[`CTRL_HIGH_SPEED_BAUD_SELECT] ? 4'h1 : 4'h4; // RULE3
	assign tick = baud_cnt_ff == 16'h0000;

	// baud tick generator, reloaded each period
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			baud_cnt_ff <= 16'h0000;
		else if (!port_on || tick)
			baud_cnt_ff <= div_val; // RULE3
		else
			baud_cnt_ff <= baud_cnt_ff - 16'h0001;
	end

	// prescale for low speed so one oversample equals one sixteenth of a bit
	logic [1:0] pre_ff;
	logic ovs_tick;
	assign ovs_tick = tick && (ovs_sel == 4'h1 || pre_ff == 2'b11);
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pre_ff <= 2'b00;
		else if (!port_on)
			pre_ff <= 2'b00;
		else if (tick)
			pre_ff <= pre_ff + 2'b01;
	end

	// sample at the middle of each bit of sixteen oversamples
	assign sample = ovs_tick && ovs_cnt_ff == `OVS_MID; // RULE1
	assign frame_done = sample && state_ff == RX_STOP;
	// address detect only in nine-bit mode; drop characters with ninth bit clear
	assign load_char = frame_done && serial_rx_pin && !oerr_ff &&
		!(ctrl_ff[`CTRL_ADDRESS_DETECT_ENABLE] && ctrl_ff[`CTRL_RX9] && !shift_ff[8]); // RULE13 RULE16 RULE15

	// receive state machine
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff <= RX_IDLE;
			ovs_cnt_ff <= 4'h0;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 9'h000;
		end
		else if (!port_on || !ctrl_ff[`CTRL_CONTINUOUS_RECEIVE_ENABLE]) // RULE6
		begin
			state_ff <= RX_IDLE;
			ovs_cnt_ff <= 4'h0;
		end
		else
		begin
			unique case (state_ff)
				RX_IDLE:
					if (!serial_rx_pin) // RULE17
					begin
						state_ff <= RX_START;
						ovs_cnt_ff <= 4'h0;
					end
				RX_START, RX_DATA, RX_STOP:
					if (ovs_tick)
					begin
						ovs_cnt_ff <= ovs_cnt_ff + 4'h1; // RULE1
						if (sample)
						begin
							if (state_ff == RX_START)
							begin
								// false start: glitch shorter than half a bit
								state_ff <= serial_rx_pin ? RX_IDLE : RX_DATA; // RULE17
								bit_cnt_ff <= 4'h0;
								shift_ff <= 9'h000;
							end
							else if (state_ff == RX_DATA)
							begin
								// lsb first into the top, shifted down per bit
								shift_ff <= {serial_rx_pin, shift_ff[8:1]}; // RULE2 RULE17
								bit_cnt_ff <= bit_cnt_ff + 4'h1;
								if (bit_cnt_ff == nbits - 4'h1)
									state_ff <= RX_STOP; // RULE5
							end
							else
								state_ff <= RX_IDLE;
						end
					end
			endcase
		end
	end

	// align the character: eight-bit mode leaves it one place high
	logic [8:0] char_al;
	assign char_al = ctrl_ff[`CTRL_RX9] ? shift_ff : {1'b0, shift_ff[8:1]};

	// holding register and status; a new character beats the read clear
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			data_ff <= 9'h000;
			ninth_ff <= 1'b0;
			rxif_ff <= 1'b0;
		end
		else if (load_char)
		begin
			data_ff <= char_al;
			ninth_ff <= char_al[8]; // RULE8
			rxif_ff <= 1'b1; // RULE7
		end
		else if (rd_data)
			rxif_ff <= 1'b0;
	end

	// errors latch until continuous receive is cleared; set wins
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ferr_ff <= 1'b0;
			oerr_ff <= 1'b0;
		end
		else
		begin
			if (frame_done && !serial_rx_pin)
				ferr_ff <= 1'b1; // RULE8
			else if (!ctrl_ff[`CTRL_CONTINUOUS_RECEIVE_ENABLE])
				ferr_ff <= 1'b0; // RULE10
			if (frame_done && serial_rx_pin && rxif_ff && !rd_data)
				oerr_ff <= 1'b1; // RULE8
			else if (!ctrl_ff[`CTRL_CONTINUOUS_RECEIVE_ENABLE])
				oerr_ff <= 1'b0; // RULE10
		end
	end

	// control registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_ff <= `CTRL_RST;
			baud_ff <= `BAUD_RST;
		end
		else if (write && !ack_ff)
		begin
			if (wr_ctrl)
				ctrl_ff <= writedata[10:0];
			if (address == `OFS_BAUD)
				baud_ff <= writedata[15:0]; // RULE3
		end
	end

	// bus answer: waitrequest high in the first cycle, low in the second
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= (read || write) && !ack_ff;
	end
	// own flop for the pin: always the inverse of ack_ff, but glitch free at the port
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && !ack_ff);
	end

	// read data registered on the first cycle, stands at the answer edge
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			readdata <= 32'h0000_0000;
		else if (read && !ack_ff)
		begin
			unique case (address)
				`OFS_CTRL: readdata <= {21'h00_0000, ctrl_ff};
				`OFS_STATUS: readdata <= {27'h000_0000, state_ff != RX_IDLE, rxif_ff,
					oerr_ff, ferr_ff, ninth_ff}; // RULE8
				`OFS_DATA: readdata <= {24'h00_0000, data_ff[7:0]}; // RULE9 RULE14
				`OFS_BAUD: readdata <= {16'h0000, baud_ff};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// interrupt routing by priority, gated by global and peripheral enables
	logic irq_req;
	assign irq_req = rxif_ff && ctrl_ff[`CTRL_RXIE] && ctrl_ff[`CTRL_GIE]
		&& ctrl_ff[`CTRL_PERIPHERAL_IRQ_ENABLE]; // RULE7 RULE11
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
		end
		else
		begin
			irq_high <= irq_req && ctrl_ff[`CTRL_RXIP]; // RULE12
			irq_low <= irq_req && !ctrl_ff[`CTRL_RXIP]; // RULE12
		end
	end

	property p_irq_gate;
		@(posedge clk) disable iff (sys_rst)
		(irq_high || irq_low) |-> $past(ctrl_ff[`CTRL_GIE] && ctrl_ff[`CTRL_PERIPHERAL_IRQ_ENABLE]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enables"); // RULE11
	property p_prio;
		@(posedge clk) disable iff (sys_rst)
		irq_high |-> $past(ctrl_ff[`CTRL_RXIP]);
	endproperty
	a_prio: assert property (p_prio) else $error("high irq with low priority"); // RULE12
	property p_flag;
		@(posedge clk) disable iff (sys_rst) load_char |=> rxif_ff;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set"); // RULE7
	property p_continuous_receive_enable_off;
		@(posedge clk) disable iff (sys_rst)
		!ctrl_ff[`CTRL_CONTINUOUS_RECEIVE_ENABLE] |=> state_ff == RX_IDLE;
	endproperty
	a_continuous_receive_enable_off: assert property (p_continuous_receive_enable_off) else $error("receiving while off"); // RULE6
	property p_err_clr;
		@(posedge clk) disable iff (sys_rst)
		(!ctrl_ff[`CTRL_CONTINUOUS_RECEIVE_ENABLE] && !frame_done) |=> !ferr_ff && !oerr_ff;
	endproperty
	a_err_clr: assert property (p_err_clr) else $error("error not cleared"); // RULE10
	property p_addr;
		@(posedge clk) disable iff (sys_rst)
		(ctrl_ff[`CTRL_ADDRESS_DETECT_ENABLE] && ctrl_ff[`CTRL_RX9] && load_char) |-> shift_ff[8];
	endproperty
	a_addr: assert property (p_addr) else $error("address char without ninth bit"); // RULE16
	property p_mode;
		@(posedge clk) disable iff (sys_rst) !port_on |=> state_ff == RX_IDLE;
	endproperty
	a_mode: assert property (p_mode) else $error("active while port off"); // RULE4
	property p_ninth;
		@(posedge clk) disable iff (sys_rst) load_char |=> ninth_ff == data_ff[8];
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit mismatch"); // RULE8
	sequence s_acc;
		(read || write) && waitrequest;
	endsequence
	property p_bus;
		@(posedge clk) disable iff (sys_rst) s_acc ##1 (read || write) |-> !waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus did not answer"); // bus answers on the second edge
endmodule

// ### serial_rx_defines.svh
/*
 register offsets, field positions, reset values and timing counts of the serial receiver.
 assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
*/
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH

`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_DATA 4'h8
`define OFS_BAUD 4'hC

`define CTRL_SERIAL_PORT_ENABLE 0
`define CTRL_CLKMODE 1
`define CTRL_RX9 2
`define CTRL_CONTINUOUS_RECEIVE_ENABLE 3
`define CTRL_ADDRESS_DETECT_ENABLE 4
`define CTRL_RXIE 5
`define CTRL_RXIP 6
`define CTRL_HIGH_SPEED_BAUD_SELECT 7
`define CTRL_WIDE_BAUD_COUNTER_SELECT 8
`define CTRL_GIE 9
`define CTRL_PERIPHERAL_IRQ_ENABLE 10
`define CTRL_RST 11'h000

`define ST_NINTH 0
`define ST_FERR 1
`define ST_OERR 2
`define ST_RXIF 3
`define ST_BUSY 4

`define BAUD_RST 16'h0000
`define OVS_MID 4'h7
`define OVS_LAST 4'hF
`endif

// ### serial_rx_pkg.sv
/*
 types shared by the serial receiver.
 assumes the defines header is included where constants are needed.
*/
package serial_rx_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;
endpackage

// ### serial_tx_model.sv
/*
 remote serial transmitter model driving the receive line.
 assumes the bench clock; bit length is given in clocks per bit.
*/
`timescale 1ns/1ns
module serial_tx_model
(
	// clock
	input wire logic clk,
	// serial line, marks high between frames
	output logic line
);
	initial line = 1'b1;

	// one frame per call; stop_ok low gives a bad stop to provoke errors
	task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stop_ok);
		for (int i = -1; i <= nb; i++)
		begin
			@(posedge clk);
			line <= (i < 0) ? 1'b0 : ((i == nb) ? stop_ok : d[i]);
			repeat (bt - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= 1'b1; // idle mark so the next start edge is clean
	endtask
endmodule
